/* rdx_pkg.sv */
// package for the decrement-register execution block
// assumes a core clock split into four phases per instruction cycle
package rdx_pkg;
    localparam int DataW = 8;
    localparam int OpW = 16;
    // opcode bits 15..9 select the operation, bit 8 the destination
    localparam logic [6:0] DecOpPattern = 7'h03;
    localparam int OpHiMsb = 15;
    localparam int OpHiLsb = 9;
    localparam int DestBit = 8;
    localparam int AddrMsb = 7;
    localparam int NibMsb = 3;
    localparam int SignBit = 7;
    localparam logic [7:0] DecOne = 8'h01;
    localparam logic [4:0] DecNibOne = 5'h01;
    localparam logic [7:0] AccReset = 8'h00;
    localparam logic [3:0] FlagsReset = 4'h0;
    // flag vector layout
    localparam int FlagZero = 0;
    localparam int FlagCarry = 1;
    localparam int FlagNibble = 2;
    localparam int FlagSigned = 3;
    typedef enum logic [1:0] {
        RDX_DECODE = 2'b00,
        RDX_READ = 2'b01,
        RDX_EXEC = 2'b11,
        RDX_WRITE = 2'b10
    } rdx_phase_t;
endpackage

/* rdx_dec_alu.sv */
// subtract-one arithmetic with the four status results
// assumes a purely combinational use inside the execution block
module rdx_dec_alu (
    input wire logic [7:0] operand,
    output logic [7:0] result,
    output logic [3:0] flags
);
    logic [8:0] full;
    logic [4:0] nib;
    always_comb begin
        // borrow convention: carry and nibble carry are set when no borrow
        full = {1'b0, operand} - {1'b0, rdx_pkg::DecOne};
        nib = {1'b0, operand[rdx_pkg::NibMsb:0]} - rdx_pkg::DecNibOne;
        result = full[rdx_pkg::DataW-1:0];
        flags = rdx_pkg::FlagsReset;
        flags[rdx_pkg::FlagZero] = (full[rdx_pkg::DataW-1:0] == 8'h00);
        flags[rdx_pkg::FlagCarry] = ~full[rdx_pkg::DataW];
        flags[rdx_pkg::FlagNibble] = ~nib[rdx_pkg::NibMsb+1];
        flags[rdx_pkg::FlagSigned] = operand[rdx_pkg::SignBit]
            & ~full[rdx_pkg::SignBit];
    end
endmodule

/* rdx_exec.sv */
// execution of the decrement-register operation over four phases
// assumes the data memory answers a read within the read phase and
// that instrWord stays stable from the decode phase to the write phase
//
// Contract
// RULE1 - take any 8-bit register address and a one-bit destination select
// RULE2 - subtract one; destination 0 writes the accumulator, register kept
// RULE3 - destination 1 writes the result back into the addressed register
// RULE4 - recognise opcode 0000 011d ffff ffff, d at bit 8
// RULE5 - update signed-range, carry, nibble-carry and zero flags only
// RULE6 - one cycle of four phases: decode, read, execute, write; zero on zero
module rdx_exec (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cycleStart,
    input wire logic [15:0] instrWord,
    input wire logic [7:0] memRdData,
    output logic [7:0] memAddr,
    output logic memRdEn,
    output logic memWrEn,
    output logic [7:0] memWrData,
    output logic [7:0] accumulator_register,
    output logic signed_range_flag,
    output logic carryFlag,
    output logic nibble_carry_flag,
    output logic zeroFlag,
    output logic decrement_register_op,
    output logic opDone
);
    // sequencer state
    rdx_pkg::rdx_phase_t phase, next_phase;
    logic active, next_active;
    // fields held for the rest of the instruction cycle
    logic destSel, next_destSel;
    logic [7:0] operand, next_operand;
    logic [7:0] result, next_result;
    logic [7:0] next_memAddr;
    // subtract-one unit
    logic [7:0] aluResult;
    logic [3:0] aluFlags;
    // next values of the registered ports
    logic next_memRdEn;
    logic next_memWrEn;
    logic [7:0] next_memWrData;
    logic [7:0] next_acc;
    logic next_opDone;
    logic next_decOp;
    logic next_signed_range_flag;
    logic next_carryFlag;
    logic next_nibble_carry_flag;
    logic next_zeroFlag;
    // phase and opcode qualifiers
    logic isDec;
    logic takeOp;
    logic inRead;
    logic inExec;
    logic inWrite;

    rdx_dec_alu uAlu (
        .operand(operand),
        .result(aluResult),
        .flags(aluFlags)
    );

    // decode of the opcode and of the current phase
    always_comb begin
        isDec = instrWord[rdx_pkg::OpHiMsb:rdx_pkg::OpHiLsb]
            == rdx_pkg::DecOpPattern; // see RULE4
        takeOp = 1'b0;
        inRead = 1'b0;
        inExec = 1'b0;
        inWrite = 1'b0;
        case (phase)
            rdx_pkg::RDX_DECODE: begin
                // a start strobe in any other phase is ignored
                takeOp = cycleStart;
            end
            rdx_pkg::RDX_READ: begin
                inRead = 1'b1;
            end
            rdx_pkg::RDX_EXEC: begin
                inExec = 1'b1;
            end
            rdx_pkg::RDX_WRITE: begin
                inWrite = 1'b1;
            end
            default: begin
                takeOp = 1'b0;
            end
        endcase
    end

    // four-phase sequencer; a non-matching opcode still steps all phases
    always_comb begin
        next_phase = phase;
        next_active = active;
        case (phase)
            rdx_pkg::RDX_DECODE: begin
                if (cycleStart) begin
                    next_active = isDec; // see RULE4
                    next_phase = rdx_pkg::RDX_READ; // see RULE6
                end
            end
            rdx_pkg::RDX_READ: begin
                next_phase = rdx_pkg::RDX_EXEC;
            end
            rdx_pkg::RDX_EXEC: begin
                next_phase = rdx_pkg::RDX_WRITE;
            end
            rdx_pkg::RDX_WRITE: begin
                next_active = 1'b0;
                next_phase = rdx_pkg::RDX_DECODE; // see RULE6
            end
            default: begin
                next_active = 1'b0;
                next_phase = rdx_pkg::RDX_DECODE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase <= rdx_pkg::RDX_DECODE;
            active <= 1'b0;
        end else begin
            phase <= next_phase;
            active <= next_active;
        end
    end

    // operation fields, operand and result held through the cycle
    always_comb begin
        next_destSel = destSel;
        next_memAddr = memAddr;
        next_operand = operand;
        next_result = result;
        if (takeOp) begin
            next_destSel = instrWord[rdx_pkg::DestBit]; // see RULE1
            next_memAddr = instrWord[rdx_pkg::AddrMsb:0]; // see RULE1
        end
        if (inRead) begin
            next_operand = memRdData;
        end
        if (inExec) begin
            next_result = aluResult; // see RULE2
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            destSel <= 1'b0;
            memAddr <= rdx_pkg::AccReset;
            operand <= rdx_pkg::AccReset;
            result <= rdx_pkg::AccReset;
        end else begin
            destSel <= next_destSel;
            memAddr <= next_memAddr;
            operand <= next_operand;
            result <= next_result;
        end
    end

    // status flags move only for a decoded decrement, nothing else
    always_comb begin
        next_signed_range_flag = signed_range_flag;
        next_carryFlag = carryFlag;
        next_nibble_carry_flag = nibble_carry_flag;
        next_zeroFlag = zeroFlag;
        if (inExec && active) begin // see RULE5
            next_signed_range_flag = aluFlags[rdx_pkg::FlagSigned];
            next_carryFlag = aluFlags[rdx_pkg::FlagCarry];
            next_nibble_carry_flag = aluFlags[rdx_pkg::FlagNibble];
            next_zeroFlag = aluFlags[rdx_pkg::FlagZero]; // see RULE6
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            signed_range_flag <= rdx_pkg::FlagsReset[rdx_pkg::FlagSigned];
            carryFlag <= rdx_pkg::FlagsReset[rdx_pkg::FlagCarry];
            nibble_carry_flag <= rdx_pkg::FlagsReset[rdx_pkg::FlagNibble];
            zeroFlag <= rdx_pkg::FlagsReset[rdx_pkg::FlagZero];
        end else begin
            signed_range_flag <= next_signed_range_flag;
            carryFlag <= next_carryFlag;
            nibble_carry_flag <= next_nibble_carry_flag;
            zeroFlag <= next_zeroFlag;
        end
    end

    // port strobes and the two destinations
    always_comb begin
        next_memRdEn = 1'b0;
        next_memWrEn = 1'b0;
        next_opDone = 1'b0;
        next_memWrData = memWrData;
        next_acc = accumulator_register;
        next_decOp = decrement_register_op;
        if (takeOp) begin
            // no read strobe for an opcode that is not a decrement
            next_memRdEn = isDec;
            next_decOp = isDec; // see RULE4
        end
        if (inWrite) begin
            if (active && destSel) begin
                next_memWrEn = 1'b1; // see RULE3
                next_memWrData = result;
            end
            if (active && !destSel) begin
                next_acc = result; // see RULE2
            end
            next_opDone = active;
            next_decOp = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            memRdEn <= 1'b0;
            memWrEn <= 1'b0;
            memWrData <= rdx_pkg::AccReset;
            accumulator_register <= rdx_pkg::AccReset;
            opDone <= 1'b0;
            decrement_register_op <= 1'b0;
        end else begin
            memRdEn <= next_memRdEn;
            memWrEn <= next_memWrEn;
            memWrData <= next_memWrData;
            accumulator_register <= next_acc;
            opDone <= next_opDone;
            decrement_register_op <= next_decOp;
        end
    end
endmodule

/* rdx_exec_properties.sv */
// assertions on the decrement-register execution ports
// assumes it is bound to rdx_exec from the bench top
module rdx_exec_chk (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cycleStart,
    input wire logic [15:0] instrWord,
    input wire logic [7:0] memRdData,
    input wire logic [7:0] memAddr,
    input wire logic memRdEn,
    input wire logic memWrEn,
    input wire logic [7:0] memWrData,
    input wire logic [7:0] accumulator_register,
    input wire logic signed_range_flag,
    input wire logic carryFlag,
    input wire logic nibble_carry_flag,
    input wire logic zeroFlag,
    input wire logic decrement_register_op,
    input wire logic opDone
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_decode_addr: assert property (memRdEn |->
        $past(instrWord[15:9]) == 7'h03 && memAddr == $past(instrWord[7:0]))
        else $error("read without matching opcode");
    a_four_phase: assert property (memRdEn |->
        decrement_register_op[*3] ##1 (!decrement_register_op && opDone))
        else $error("phase sequence broken");
    a_zero_flag: assert property (memRdEn |-> ##2
        zeroFlag == ($past(memRdData, 2) == 8'h01)) else $error("zero flag");
    a_status_flags: assert property (memRdEn |-> ##2
        {signed_range_flag, nibble_carry_flag, carryFlag} ==
        {$past(memRdData, 2) == 8'h80, $past(memRdData[3:0], 2) != 4'h0,
        $past(memRdData, 2) != 8'h00}) else $error("status flags");
    a_wr_value: assert property (memWrEn |->
        memWrData == $past(memRdData, 3) - 8'h01) else $error("write data");
    a_dest_select: assert property (opDone |->
        memWrEn == $past(instrWord[8])) else $error("destination select");
    a_acc_kept: assert property (memWrEn |->
        $stable(accumulator_register)) else $error("accumulator moved");
    a_acc_value: assert property (opDone && !memWrEn |->
        accumulator_register == $past(memRdData, 3) - 8'h01)
        else $error("accumulator value");
endmodule

/* tb_top.sv */
// self-checking bench for the decrement-register execution block
// assumes one 250 MHz clock and an active-low asynchronous reset
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, nrst = 1'b0, cycleStart = 1'b0;
    logic [15:0] instrWord = 16'h0000;
    logic [7:0] memRdData = 8'h00, memAddr, memWrData, accumulator_register;
    logic memRdEn, memWrEn, signed_range_flag, carryFlag;
    logic nibble_carry_flag, zeroFlag, decrement_register_op, opDone;
    logic [7:0] acc = 8'h00;
    logic [3:0] fl = 4'h0;
    logic [31:0] seed = 32'h0000004f;
    logic [31:0] v;
    int n_mismatch = 0, checks = 0;
    always #2 sys_clk = ~sys_clk;
    rdx_exec i_rdx_exec (.*);
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic run(input logic [15:0] op, input logic [7:0] d);
        logic hit;
        logic [7:0] r;
        logic [3:0] flagsSeen;
        hit = op[15:9] == 7'h03;
        r = d - 8'h01;
        @(posedge sys_clk) #1;
        cycleStart = 1'b1;
        instrWord = op;
        @(posedge sys_clk) #1;
        // a start strobe left high into the read phase must be ignored
        cycleStart = d[0];
        memRdData = d;
        chk("rden", 8'(hit), 8'(memRdEn));
        chk("decop", 8'(hit), 8'(decrement_register_op));
        if (hit) chk("addr", op[7:0], memAddr);
        @(posedge sys_clk) #1;
        cycleStart = 1'b0;
        memRdData = ~d;
        chk("rden2", 8'h00, 8'(memRdEn));
        repeat (2) @(posedge sys_clk);
        #1;
        if (hit) fl = {d == 8'h80, d[3:0] != 4'h0, d != 8'h00, r == 8'h00};
        if (hit && !op[8]) acc = r;
        flagsSeen = {signed_range_flag, nibble_carry_flag, carryFlag,
            zeroFlag};
        chk("done", 8'(hit), 8'(opDone));
        chk("decop2", 8'h00, 8'(decrement_register_op));
        chk("wren", 8'(hit & op[8]), 8'(memWrEn));
        if (hit & op[8]) chk("wdata", r, memWrData);
        chk("acc", acc, accumulator_register);
        chk("flags", 8'(fl), 8'(flagsSeen));
        @(posedge sys_clk) #1;
        chk("done2", 8'h00, 8'(opDone));
        chk("wren2", 8'h00, 8'(memWrEn));
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        #1 nrst = 1'b1;
        run(16'h0610, 8'h01);
        run(16'h0700, 8'h00);
        run(16'h07ff, 8'h10);
        run(16'h0680, 8'h80);
        run(16'h1610, 8'h05);
        for (int i = 0; i < 60; i++) begin
            v = xs();
            run({v[31] ? 7'h03 : v[30:24], v[8:0]}, v[16:9]);
        end
        tally_and_finish();
    end
endmodule
bind rdx_exec rdx_exec_chk i_rdx_exec_chk (.*);
